//--- wdcs_consts.svh
// Constants for the watchdog control/status block: field positions,
// reset values and register offsets.
// Assumes inclusion by the package and the block only.
`ifndef WDCS_CONSTS_SVH
`define WDCS_CONSTS_SVH

`define WDCS_CTRL_STATUS_OFS   4'h0
`define WDCS_COUNTER_OFS       4'h1
`define WDCS_FLAG_BIT          7
`define WDCS_MODE_BIT          6
`define WDCS_EN_BIT            5
`define WDCS_SRC_BIT           4
`define WDCS_ACT_BIT           3
`define WDCS_CTRL_RESET        8'h00
`define WDCS_CNT_MAX           8'hff
`define WDCS_CNT_ZERO          8'h00

`endif

//--- wdcs_pkg.sv
// Types shared by the watchdog control/status block.
// Assumes wdcs_consts.svh is on the include path.
`default_nettype none
`include "wdcs_consts.svh"

package wdcs_pkg;
	typedef struct packed {
		logic       overflow_flag;
		logic       timer_mode_select;
		logic       count_enable_bit;
		logic       prescaler_source_select;
		logic       overflow_action;
		logic [2:0] tap_select;
		logic [7:0] watchdog_counter;
		logic       flag_read_armed;
		logic       tick_sys_s1;
		logic       tick_sys_s2;
		logic       tick_sys_d;
		logic       tick_sub_s1;
		logic       tick_sub_s2;
		logic       tick_sub_d;
		logic [7:0] rd_data;
		logic       nmi_req;
		logic       reset_req;
	} wdcs_state_t;
endpackage

`default_nettype wire

//--- wdcs_watchdog.sv
// Watchdog control/status block: 8-bit counter, overflow flag and
// overflow action, registers over a plain strobe port.
// Assumes prescaler taps arrive as levels from another domain; the chip
// applies nrst when reset_req pulses.
//
// Function
// - Set overflow flag when counter wraps from all-ones to zero.
// - Internal reset request in watchdog mode clears the overflow flag.
// - Flag cleared by writing 0 only after a read that saw it set.
// - Writing 0 to count enable clears the overflow flag.
// - Mode bit 6: 0 interval timer, 1 watchdog timer; resets to 0.
// - Count enable bit 5 starts counting when set; resets to 0.
// - Clearing count enable halts the counter and zeroes it.
// - Source bit 4 picks system or sub-clock prescaler tap.
// - Action bit 3 at 0 makes a watchdog-mode overflow request an interrupt; interval mode requests nothing.
// - Action bit at 1 makes a watchdog-mode overflow request an internal reset.
//
// Added by the designer: the placing of the registers and strobed register access.
`default_nettype none
`include "wdcs_consts.svh"

module wdcs_watchdog
	import wdcs_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic       sys_tap,
	input  wire logic       sub_tap,
	output logic      [7:0] reg_rdata,
	output logic      [2:0] tap_select,
	output logic      [7:0] watchdog_counter,
	output logic            overflow_flag,
	output logic            nmi_req,
	output logic            reset_req
);

	wdcs_state_t st_reg;
	wdcs_state_t st_next;

	// Control byte after reset; every control field starts from it
	localparam logic [7:0] CTRL_RST = `WDCS_CTRL_RESET;

	// Whole-state reset image. The tap pipelines start low, at the idle
	// level of the taps, so no false edge is counted just after reset.
	localparam wdcs_state_t WDCS_RESET_STATE = '{
		overflow_flag:           CTRL_RST[`WDCS_FLAG_BIT],
		timer_mode_select:       CTRL_RST[`WDCS_MODE_BIT],
		count_enable_bit:        CTRL_RST[`WDCS_EN_BIT],
		prescaler_source_select: CTRL_RST[`WDCS_SRC_BIT],
		overflow_action:         CTRL_RST[`WDCS_ACT_BIT],
		tap_select:              CTRL_RST[2:0],
		watchdog_counter:        `WDCS_CNT_ZERO,
		flag_read_armed:         1'b0,
		tick_sys_s1:             1'b0,
		tick_sys_s2:             1'b0,
		tick_sys_d:              1'b0,
		tick_sub_s1:             1'b0,
		tick_sub_s2:             1'b0,
		tick_sub_d:              1'b0,
		rd_data:                 8'h00,
		nmi_req:                 1'b0,
		reset_req:               1'b0
	};

	// Register image of the control fields, as software reads it
	function automatic logic [7:0] wdcs_ctrl_image(input wdcs_state_t s);
		logic [7:0] img;
		img                 = 8'h00;
		img[`WDCS_FLAG_BIT] = s.overflow_flag;
		img[`WDCS_MODE_BIT] = s.timer_mode_select;
		img[`WDCS_EN_BIT]   = s.count_enable_bit;
		img[`WDCS_SRC_BIT]  = s.prescaler_source_select;
		img[`WDCS_ACT_BIT]  = s.overflow_action;
		img[2:0]            = s.tap_select;
		return img;
	endfunction

	// One-cycle pulse on a rising edge of a synchronised tap level
	function automatic logic wdcs_rise(input logic lvl, input logic lvl_d);
		return lvl & ~lvl_d;
	endfunction

	always_comb begin
		logic       sys_edge;
		logic       sub_edge;
		logic       sel_edge;
		logic       wrap;
		logic       hit_ctrl;
		logic       hit_cnt;
		logic       ctrl_wr;
		logic       ctrl_rd;
		logic       clear_ok;
		sys_edge = 1'b0;
		sub_edge = 1'b0;
		sel_edge = 1'b0;
		wrap     = 1'b0;
		hit_ctrl = 1'b0;
		hit_cnt  = 1'b0;
		ctrl_wr  = 1'b0;
		ctrl_rd  = 1'b0;
		clear_ok = 1'b0;
		st_next  = st_reg;

		// Taps come from another clock domain: two flops each, and only
		// stage two feeds the edge detect, so a metastable first stage
		// never reaches the counter
		st_next.tick_sys_s1 = sys_tap;
		st_next.tick_sys_s2 = st_reg.tick_sys_s1;
		st_next.tick_sys_d  = st_reg.tick_sys_s2;
		st_next.tick_sub_s1 = sub_tap;
		st_next.tick_sub_s2 = st_reg.tick_sub_s1;
		st_next.tick_sub_d  = st_reg.tick_sub_s2;
		sys_edge = wdcs_rise(st_reg.tick_sys_s2, st_reg.tick_sys_d);
		sub_edge = wdcs_rise(st_reg.tick_sub_s2, st_reg.tick_sub_d);

		// Both pipelines run all the time; a source switch that lands on
		// an edge of the new tap may still count once
		// tap source select
		if (st_reg.prescaler_source_select) begin
			sel_edge = sub_edge;
		end else begin
			sel_edge = sys_edge;
		end

		// Register decode
		hit_ctrl = (reg_addr == `WDCS_CTRL_STATUS_OFS);
		hit_cnt  = (reg_addr == `WDCS_COUNTER_OFS);
		ctrl_wr  = reg_wr & hit_ctrl;
		ctrl_rd  = reg_rd & hit_ctrl;

		// Request outputs are one-cycle pulses
		st_next.nmi_req   = 1'b0;
		st_next.reset_req = 1'b0;

		if (st_reg.count_enable_bit && sel_edge) begin
			wrap = (st_reg.watchdog_counter == `WDCS_CNT_MAX);
			st_next.watchdog_counter = st_reg.watchdog_counter + 8'h01;
		end

		// Read data stand for the one cycle after the strobe, else zero;
		// the counter reads at its own offset, other offsets read zero
		st_next.rd_data = 8'h00;
		if (ctrl_rd) begin
			st_next.rd_data = wdcs_ctrl_image(st_reg);
		end else if (reg_rd && hit_cnt) begin
			st_next.rd_data = st_reg.watchdog_counter;
		end

		// read of set flag arms clear
		if (ctrl_rd && st_reg.overflow_flag) begin
			st_next.flag_read_armed = 1'b1;
		end

		if (ctrl_wr) begin
			st_next.timer_mode_select = reg_wdata[`WDCS_MODE_BIT];
			st_next.count_enable_bit = reg_wdata[`WDCS_EN_BIT];
			st_next.prescaler_source_select = reg_wdata[`WDCS_SRC_BIT];
			st_next.overflow_action = reg_wdata[`WDCS_ACT_BIT];
			// Tap select feeds the prescaler outside this block; inside it is only read back
			st_next.tap_select = reg_wdata[2:0];
			// only a 0 after an armed read clears; a 1 is
			// ignored, so a control update that writes 1 and keeps count enable set leaves the flag alone
			clear_ok = !reg_wdata[`WDCS_FLAG_BIT] &&
				st_reg.flag_read_armed;
			if (clear_ok) begin
				st_next.overflow_flag   = 1'b0;
				st_next.flag_read_armed = 1'b0;
			end
			// disable clears flag and zeroes counter; it also
			// drops a same-cycle wrap, since counting stops at once
			if (!reg_wdata[`WDCS_EN_BIT]) begin
				st_next.overflow_flag    = 1'b0;
				st_next.flag_read_armed  = 1'b0;
				st_next.watchdog_counter = `WDCS_CNT_ZERO;
				wrap = 1'b0;
			end
		end

		if (wrap) begin
			// set wins over a same-cycle clear by an armed write of 0
			st_next.overflow_flag = 1'b1;
			if (st_reg.timer_mode_select) begin
				if (st_reg.overflow_action) begin
					st_next.reset_req = 1'b1;
					st_next.overflow_flag   = 1'b0;
					st_next.flag_read_armed = 1'b0;
				end else begin
					st_next.nmi_req = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= WDCS_RESET_STATE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata        = st_reg.rd_data;
	assign tap_select       = st_reg.tap_select;
	assign watchdog_counter = st_reg.watchdog_counter;
	assign overflow_flag    = st_reg.overflow_flag;
	assign nmi_req          = st_reg.nmi_req;
	assign reset_req        = st_reg.reset_req;

endmodule

`default_nettype wire

//--- wdcs_props.sv
// Port checker for the watchdog control/status block.
// Assumes it is bound to wdcs_watchdog.
`default_nettype none
module wdcs_props (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic [7:0] watchdog_counter,
	input wire logic       overflow_flag,
	input wire logic       nmi_req,
	input wire logic       reset_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire logic ctl_wr = reg_wr && reg_addr == 4'h0;
	a_nmi_flag: assert property (nmi_req |-> overflow_flag
		&& watchdog_counter == 8'h00) else $error("nmi without wrap");
	a_rst_clears: assert property (reset_req |-> !overflow_flag
		&& watchdog_counter == 8'h00) else $error("reset kept flag");
	a_flag_hold: assert property (overflow_flag && !ctl_wr
		|=> overflow_flag || reset_req) else $error("flag lost");
	a_en_off: assert property (ctl_wr && !reg_wdata[5]
		|=> watchdog_counter == 8'h00 && !overflow_flag)
		else $error("disable did not clear");
	a_one_set: assert property (!overflow_flag && ctl_wr
		&& reg_wdata[7] |=> !overflow_flag || watchdog_counter == 8'h00)
		else $error("flag set by write");
	a_step_one: assert property ($changed(watchdog_counter)
		&& watchdog_counter != 8'h00 |-> watchdog_counter ==
		$past(watchdog_counter) + 8'h01) else $error("bad count step");
	a_one_req: assert property (!(nmi_req && reset_req))
		else $error("both requests");
	a_req_pulse: assert property (nmi_req |=> !nmi_req
		&& !reset_req) else $error("nmi too long");
	cover property (nmi_req);
	cover property (reset_req);
	cover property (overflow_flag ##1 !overflow_flag);
endmodule
`default_nettype wire

//--- wdcs_watchdog_tb.sv
// Self-checking bench for the watchdog control/status block.
// Assumes the package, design and checker are compiled first.
`default_nettype none
module wdcs_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0;
	logic       reg_rd = 1'h0, sys_tap = 1'h0, sub_tap = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	wire  [7:0] reg_rdata, watchdog_counter;
	wire        overflow_flag, nmi_req, reset_req;
	wire  [2:0] tap_select;
	int         n_errors = 0, samples_checked = 0, n_nmi = 0, n_rst = 0;
	wdcs_watchdog i_wdcs_watchdog (.sys_clk, .nrst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .sys_tap, .sub_tap, .reg_rdata,
		.tap_select, .watchdog_counter, .overflow_flag, .nmi_req,
		.reset_req);
	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		n_nmi <= n_nmi + nmi_req;
		n_rst <= n_rst + reset_req;
	end
	task chk(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= 4'h0;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, exp);
	endtask
	// Taps are slow levels: two cycles high, two low, then settle time
	task tick(input bit sub, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			if (sub) sub_tap <= 1'h1;
			else sys_tap <= 1'h1;
			repeat (2) @(posedge sys_clk);
			sys_tap <= 1'h0;
			sub_tap <= 1'h0;
			@(posedge sys_clk);
		end
		repeat (4) @(posedge sys_clk);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000 n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'h1;
		rd(4'h0, 8'h00);
		wr(8'h20);
		tick(0, 3);
		chk(watchdog_counter, 8'h03);
		tick(1, 2);
		rd(4'h1, 8'h03);
		wr(8'h30);
		tick(1, 2);
		rd(4'h1, 8'h05);
		wr(8'h00);
		rd(4'h1, 8'h00);
		chk(watchdog_counter, 8'h00);
		wr(8'h07);
		rd(4'h0, 8'h07);
		chk({5'h00, tap_select}, 8'h07);
		wr(8'ha0);
		rd(4'h0, 8'h20);
		chk({7'h00, overflow_flag}, 8'h00);
		$display("test counting done");
		tick(0, 256);
		chk({7'h00, overflow_flag}, 8'h01);
		wr(8'h20);
		rd(4'h0, 8'ha0);
		wr(8'h20);
		rd(4'h0, 8'h20);
		chk({7'h00, overflow_flag}, 8'h00);
		chk(n_nmi[7:0], 8'h00);
		wr(8'h60);
		tick(0, 256);
		chk(n_nmi[7:0], 8'h01);
		rd(4'h0, 8'he0);
		wr(8'h40);
		rd(4'h0, 8'h40);
		chk({7'h00, overflow_flag}, 8'h00);
		wr(8'h68);
		tick(0, 256);
		chk(n_rst[7:0], 8'h01);
		chk(n_nmi[7:0], 8'h01);
		rd(4'h0, 8'h68);
		$display("test overflow done");
		tally_and_finish;
	end
endmodule
bind wdcs_watchdog wdcs_props i_wdcs_props (.sys_clk, .nrst, .reg_addr,
	.reg_wdata, .reg_wr, .watchdog_counter, .overflow_flag, .nmi_req,
	.reset_req);
`default_nettype wire
